/* File: logic/amc_pkg.sv */
// Shared constants and state types for the converter control link.
package amc_pkg;
  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 20;
  localparam int unsigned OSC_START_US     = 165;
  localparam int unsigned OSC_START_CYC    = (OSC_START_US * 1000 + CLK_PERIOD_NS - 1)
                                             / CLK_PERIOD_NS;
  localparam int unsigned CONV_CH_US       = 2;
  localparam int unsigned CONV_CH_CYC      = (CONV_CH_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned OSC_MHZ          = 10;
  localparam int unsigned CONV_CLKS_PER_CH = CONV_CH_US * OSC_MHZ;
  localparam int unsigned RST_WAIT_US      = 5;
  localparam int unsigned RST_WAIT_CYC     = (RST_WAIT_US * 1000 + CLK_PERIOD_NS - 1)
                                             / CLK_PERIOD_NS;
  localparam int unsigned WAKE_MS          = 20;
  localparam int unsigned WAKE_CYC         = (WAKE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned WR_LO_CYC        = 2;
  localparam int unsigned CV_LO_CYC        = 2;
  localparam int unsigned RD_LO_CYC        = 3;
  localparam int unsigned RD_HI_CYC        = 2;
  localparam int unsigned CNT_W            = 24;
  // --------------------------------------------------------------------
  // Control word layout
  // --------------------------------------------------------------------
  localparam int unsigned DATA_W     = 12;
  localparam int unsigned N_CH       = 4;
  localparam int unsigned PD_BIT     = 3;
  localparam int unsigned BANK_BIT   = 2;
  localparam logic [2:0]  MODE_RESET = 3'h0;
  // --------------------------------------------------------------------
  // Host register map and status bits
  // --------------------------------------------------------------------
  localparam logic [3:0] REG_WORD  = 4'h0;
  localparam logic [3:0] REG_START = 4'h1;
  localparam logic [3:0] REG_SEL   = 4'h2;
  localparam logic [3:0] REG_STAT  = 4'h3;
  localparam logic [3:0] REG_MASK  = 4'h4;
  localparam logic [3:0] REG_RES0  = 4'h5;
  localparam logic [3:0] REG_LATCH = 4'h9;
  localparam int unsigned EV_DONE   = 0;
  localparam int unsigned EV_READY  = 1;
  localparam int unsigned EV_REFUSE = 2;
  localparam int unsigned N_EV      = 3;
  localparam int unsigned LV_BUSY   = 8;
  localparam int unsigned LV_WAIT   = 9;
  // --------------------------------------------------------------------
  // State types
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {D_START, D_IDLE, D_CONV, D_PD} amc_dev_state_t;
  typedef enum logic [2:0] {H_WAIT, H_IDLE, H_WR, H_WEND, H_CV, H_WDONE, H_RDL,
                            H_RDH} amc_host_state_t;
endpackage : amc_pkg

/* File: logic/amc_link_if.sv */
// Parallel bus between the converter and its host.
`timescale 1ns/10ps
interface amc_link_if;
  logic        cs_n;
  logic        wr_n;
  logic        rd_n;
  logic        convert_start_n;
  logic        done_n;
  logic [1:0]  addr_bits;
  logic [11:0] host_dout;
  logic        host_oe;
  logic [11:0] dev_dout;
  logic        dev_oe;
  logic [11:0] data;

  // Resolved level of the shared data pins; an undriven bus reads as zero.
  assign data = dev_oe ? dev_dout : (host_oe ? host_dout : 12'h000);

  modport dev (input cs_n, input wr_n, input rd_n, input convert_start_n,
               input addr_bits, input data, output done_n, output dev_dout,
               output dev_oe);
  modport host (output cs_n, output wr_n, output rd_n, output convert_start_n,
                output addr_bits, output host_dout, output host_oe,
                input data, input done_n);
endinterface : amc_link_if

/* File: logic/amc_device.sv */
// Converter end: mode control, power-down, conversion sequencer, result readout.
//
// Summary of operation
// - Clock pin high: internal oscillator after startup.
// - External clock duty cycle kept within 30-70%.
// - Reset: done high, ready, bank A single.
// - Host waits reset interval before converting.
// - Result memory undefined until first conversion.
// - Power-down bit set powers down on latch.
// - Powered down: interface still accepts control words.
// - Power-down bit clear wakes into coded mode.
// - Host waits power-up delay after wake.
// - Results coded in two's complement.
// - Host reads four words, latches selected channel.
// - Word: bank bit, channel count minus one.
// - Word latched on write or select rising.
// - Reads return channels in order, pointer wraps.
`timescale 1ns/10ps
module amc_device #(
  parameter int unsigned OSC_START_CYC = amc_pkg::OSC_START_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  amc_link_if.dev          link,
  input  wire logic        clk_pin_i,
  input  wire logic [47:0] samp_a_i,
  input  wire logic [47:0] samp_b_i,
  output logic             ready_o,
  output logic             busy_o,
  output logic             powered_down_o,
  output logic [2:0]       mode_o
);
  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------

  // Picks one 12-bit channel out of a packed group of four.
  function automatic logic [11:0] amc_slice(input logic [47:0] v, input logic [1:0] i);
    amc_slice = v[32'(i) * 12 +: 12];
  endfunction : amc_slice

  // Turns the offset-binary converter output into two's complement.
  function automatic logic [11:0] amc_twos(input logic [11:0] ob);
    amc_twos = {~ob[11], ob[10:0]};
  endfunction : amc_twos

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  amc_pkg::amc_dev_state_t state_reg,    state_next;
  logic [amc_pkg::CNT_W-1:0] cnt_reg,    cnt_next;
  logic [2:0]                mode_reg,   mode_next;
  logic [1:0]                ch_reg,     ch_next;
  logic [1:0]                last_reg,   last_next;
  logic [1:0]                ptr_reg,    ptr_next;
  logic                      int_osc_reg, int_osc_next;
  logic                      done_n_reg, done_n_next;
  logic [11:0]               dout_reg,   dout_next;
  logic                      oe_reg,     oe_next;
  logic [47:0]               hold_reg,   hold_next;
  logic                      cs_q;
  logic                      wr_q;
  logic                      rd_q;
  logic                      cv_q;
  logic                      pin_q;
  logic [1:0]                dat_q;
  logic [1:0]                a_q;
  logic [11:0]               mem [amc_pkg::N_CH];
  logic                      mem_we;
  logic [1:0]                mem_idx;
  logic [11:0]               mem_wdata;
  logic                      latch_ev;
  logic                      rd_fall;
  logic                      rd_rise;
  logic                      cv_rise;
  logic                      tick;
  logic [amc_pkg::CNT_W-1:0] lim;
  logic [3:0]                word;

  // --------------------------------------------------------------------
  // Pin edge detection
  // --------------------------------------------------------------------

  // Word is latched when write or select rises while both were low.
  assign latch_ev = ~cs_q & ~wr_q & (link.wr_n | link.cs_n);
  assign word     = {dat_q, a_q};
  assign rd_fall  = ~link.cs_n & rd_q & ~link.rd_n;
  assign rd_rise  = ~cs_q & ~rd_q & link.rd_n;
  assign cv_rise  = ~cv_q & link.convert_start_n;

  // Conversion steps count system clocks or external clock rising edges.
  assign tick = int_osc_reg | (~pin_q & clk_pin_i);
  assign lim  = int_osc_reg ? amc_pkg::CNT_W'(amc_pkg::CONV_CH_CYC - 1)
                            : amc_pkg::CNT_W'(amc_pkg::CONV_CLKS_PER_CH - 1);

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------

  // Sequencer, mode word handling and readout pointer.
  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    mode_next    = mode_reg;
    ch_next      = ch_reg;
    last_next    = last_reg;
    ptr_next     = ptr_reg;
    int_osc_next = int_osc_reg;
    done_n_next  = done_n_reg;
    dout_next    = dout_reg;
    oe_next      = oe_reg;
    hold_next    = hold_reg;
    mem_we       = 1'b0;
    mem_idx      = ch_reg;
    mem_wdata    = amc_twos(amc_slice(hold_reg, ch_reg));
    case (state_reg)
      amc_pkg::D_START: begin
        if (!clk_pin_i) begin
          int_osc_next = 1'b0;
          state_next   = amc_pkg::D_IDLE;
        end else if (cnt_reg == amc_pkg::CNT_W'(OSC_START_CYC - 1)) begin
          int_osc_next = 1'b1;
          state_next   = amc_pkg::D_IDLE;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      amc_pkg::D_IDLE: begin
        if (cv_rise) begin
          hold_next  = mode_reg[amc_pkg::BANK_BIT] ? samp_b_i : samp_a_i;
          last_next  = mode_reg[1:0];
          ch_next    = 2'h0;
          cnt_next   = '0;
          state_next = amc_pkg::D_CONV;
        end
      end
      amc_pkg::D_CONV: begin
        if (tick) begin
          if (cnt_reg == lim) begin
            mem_we   = 1'b1;
            cnt_next = '0;
            if (ch_reg == last_reg) begin
              done_n_next = 1'b0;
              state_next  = amc_pkg::D_IDLE;
            end else begin
              ch_next = ch_reg + 2'h1;
            end
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
      end
      amc_pkg::D_PD: begin
        // Converter and reference buffer are off; only the interface runs.
        cnt_next = '0;
      end
      default: begin
        state_next = amc_pkg::D_START;
      end
    endcase
    // Outside start-up, a latched word either powers down or selects the mode.
    if (latch_ev && state_reg != amc_pkg::D_START) begin
      if (word[amc_pkg::PD_BIT]) begin
        state_next = amc_pkg::D_PD;
      end else begin
        mode_next = word[2:0];
        if (state_reg == amc_pkg::D_PD) begin
          state_next = amc_pkg::D_IDLE;
        end
      end
    end
    // Readout: first falling read drives channel 0 and releases done.
    if (rd_fall) begin
      dout_next   = mem[ptr_reg];
      oe_next     = 1'b1;
      done_n_next = 1'b1;
    end
    if (rd_rise) begin
      ptr_next = ptr_reg + 2'h1;
      oe_next  = 1'b0;
    end
    if (link.cs_n) begin
      oe_next = 1'b0;
    end
    if (cv_rise) begin
      ptr_next = 2'h0;
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------

  // Control state with its power-on values.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg   <= amc_pkg::D_START;
      cnt_reg     <= '0;
      mode_reg    <= amc_pkg::MODE_RESET;
      ch_reg      <= 2'h0;
      last_reg    <= 2'h0;
      ptr_reg     <= 2'h0;
      int_osc_reg <= 1'b0;
      done_n_reg  <= 1'b1;
      dout_reg    <= 12'h000;
      oe_reg      <= 1'b0;
      hold_reg    <= 48'h000000000000;
      cs_q        <= 1'b1;
      wr_q        <= 1'b1;
      rd_q        <= 1'b1;
      cv_q        <= 1'b1;
      pin_q       <= 1'b0;
      dat_q       <= 2'h0;
      a_q         <= 2'h0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      mode_reg    <= mode_next;
      ch_reg      <= ch_next;
      last_reg    <= last_next;
      ptr_reg     <= ptr_next;
      int_osc_reg <= int_osc_next;
      done_n_reg  <= done_n_next;
      dout_reg    <= dout_next;
      oe_reg      <= oe_next;
      hold_reg    <= hold_next;
      cs_q        <= link.cs_n;
      wr_q        <= link.wr_n;
      rd_q        <= link.rd_n;
      cv_q        <= link.convert_start_n;
      pin_q       <= clk_pin_i;
      dat_q       <= link.data[1:0];
      a_q         <= link.addr_bits;
    end
  end

  // Result memory has no reset, so it reads as unknown until written.
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem[mem_idx] <= mem_wdata;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------

  // Pins come straight from registers; status levels are decoded from the state register.
  assign link.done_n    = done_n_reg;
  assign link.dev_dout  = dout_reg;
  assign link.dev_oe    = oe_reg;
  assign ready_o        = (state_reg == amc_pkg::D_IDLE);
  assign busy_o         = (state_reg == amc_pkg::D_CONV);
  assign powered_down_o = (state_reg == amc_pkg::D_PD);
  assign mode_o         = mode_reg;
endmodule : amc_device

/* File: logic/amc_host.sv */
// Host end: register port, wait timers, write, convert and four-word readout.
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
module amc_host #(
  parameter int unsigned WAKE_CYC = amc_pkg::WAKE_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  amc_link_if.host         link,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [15:0]      rdata_o,
  output logic             irq_o
);
  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  amc_pkg::amc_host_state_t  state_reg, state_next;
  logic [amc_pkg::CNT_W-1:0] cnt_reg,   cnt_next;
  logic                      wake_reg,  wake_next;
  logic                      pd_reg,    pd_next;
  logic [3:0]                word_reg,  word_next;
  logic [1:0]                sel_reg,   sel_next;
  logic [1:0]                idx_reg,   idx_next;
  logic [11:0]               latch_reg, latch_next;
  logic [11:0]               res_reg [amc_pkg::N_CH];
  logic                      res_we;
  logic [amc_pkg::N_EV-1:0]  st_reg,    st_next;
  logic [amc_pkg::N_EV-1:0]  mask_reg,  mask_next;
  logic [amc_pkg::N_EV-1:0]  ev;
  logic                      irq_reg,   irq_next;
  logic [15:0]               rdata_reg, rdata_next;
  logic                      cs_n_reg,  cs_n_next;
  logic                      wr_n_reg,  wr_n_next;
  logic                      rd_n_reg,  rd_n_next;
  logic                      cv_n_reg,  cv_n_next;
  logic                      oe_reg,    oe_next;
  logic [amc_pkg::CNT_W-1:0] wait_lim;
  logic                      word_req;
  logic                      start_req;

  assign word_req  = wr_i && addr_i == amc_pkg::REG_WORD;
  assign start_req = wr_i && addr_i == amc_pkg::REG_START;
  assign wait_lim  = wake_reg ? amc_pkg::CNT_W'(WAKE_CYC - 1)
                              : amc_pkg::CNT_W'(amc_pkg::RST_WAIT_CYC - 1);

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------

  // Link sequencer, event flags and register reads.
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    wake_next  = wake_reg;
    pd_next    = pd_reg;
    word_next  = word_reg;
    idx_next   = idx_reg;
    latch_next = latch_reg;
    cs_n_next  = cs_n_reg;
    wr_n_next  = wr_n_reg;
    rd_n_next  = rd_n_reg;
    cv_n_next  = cv_n_reg;
    oe_next    = oe_reg;
    res_we     = 1'b0;
    ev         = '0;
    case (state_reg)
      amc_pkg::H_WAIT: begin
        if (cnt_reg == wait_lim) begin
          ev[amc_pkg::EV_READY] = 1'b1;
          state_next = amc_pkg::H_IDLE;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      amc_pkg::H_IDLE: begin
        cnt_next = '0;
        if (word_req) begin
          word_next  = wdata_i[3:0];
          cs_n_next  = 1'b0;
          oe_next    = 1'b1;
          wr_n_next  = 1'b0;
          state_next = amc_pkg::H_WR;
        end else if (start_req) begin
          if (pd_reg) begin
            ev[amc_pkg::EV_REFUSE] = 1'b1;
          end else begin
            cv_n_next  = 1'b0;
            state_next = amc_pkg::H_CV;
          end
        end
      end
      amc_pkg::H_WR: begin
        if (cnt_reg == amc_pkg::CNT_W'(amc_pkg::WR_LO_CYC - 1)) begin
          wr_n_next  = 1'b1;
          state_next = amc_pkg::H_WEND;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      amc_pkg::H_WEND: begin
        cs_n_next = 1'b1;
        oe_next   = 1'b0;
        cnt_next  = '0;
        if (word_reg[amc_pkg::PD_BIT]) begin
          pd_next    = 1'b1;
          state_next = amc_pkg::H_IDLE;
        end else if (pd_reg) begin
          pd_next    = 1'b0;
          wake_next  = 1'b1;
          state_next = amc_pkg::H_WAIT;
        end else begin
          state_next = amc_pkg::H_IDLE;
        end
      end
      amc_pkg::H_CV: begin
        if (cnt_reg == amc_pkg::CNT_W'(amc_pkg::CV_LO_CYC - 1)) begin
          cv_n_next  = 1'b1;
          state_next = amc_pkg::H_WDONE;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      amc_pkg::H_WDONE: begin
        cnt_next = '0;
        idx_next = 2'h0;
        if (!link.done_n) begin
          cs_n_next  = 1'b0;
          rd_n_next  = 1'b0;
          state_next = amc_pkg::H_RDL;
        end
      end
      amc_pkg::H_RDL: begin
        if (cnt_reg == amc_pkg::CNT_W'(amc_pkg::RD_LO_CYC - 1)) begin
          res_we = 1'b1;
          if (idx_reg == sel_reg) begin
            latch_next = link.data;
          end
          rd_n_next  = 1'b1;
          cnt_next   = '0;
          state_next = amc_pkg::H_RDH;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      amc_pkg::H_RDH: begin
        if (cnt_reg == amc_pkg::CNT_W'(amc_pkg::RD_HI_CYC - 1)) begin
          cnt_next = '0;
          if (idx_reg == 2'h3) begin
            cs_n_next  = 1'b1;
            ev[amc_pkg::EV_DONE] = 1'b1;
            state_next = amc_pkg::H_IDLE;
          end else begin
            idx_next   = idx_reg + 2'h1;
            rd_n_next  = 1'b0;
            state_next = amc_pkg::H_RDL;
          end
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      default: begin
        state_next = amc_pkg::H_WAIT;
      end
    endcase
    // Commands while a wait or transfer runs are refused.
    if ((word_req || start_req) && state_reg != amc_pkg::H_IDLE) begin
      ev[amc_pkg::EV_REFUSE] = 1'b1;
    end
    // Sticky flags: a new event wins over a write-one clear.
    st_next = st_reg;
    if (wr_i && addr_i == amc_pkg::REG_STAT) begin
      st_next = st_reg & ~wdata_i[amc_pkg::N_EV-1:0];
    end
    st_next   = st_next | ev;
    mask_next = (wr_i && addr_i == amc_pkg::REG_MASK) ? wdata_i[amc_pkg::N_EV-1:0]
                                                       : mask_reg;
    sel_next  = (wr_i && addr_i == amc_pkg::REG_SEL) ? wdata_i[1:0] : sel_reg;
    irq_next  = |(st_next & mask_next);
    // Read data stands only in the cycle after the read strobe.
    rdata_next = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        amc_pkg::REG_WORD:  rdata_next = {12'h000, word_reg};
        amc_pkg::REG_SEL:   rdata_next = {14'h0000, sel_reg};
        amc_pkg::REG_STAT: begin
          rdata_next = {13'h0000, st_reg};
          rdata_next[amc_pkg::LV_BUSY] = (state_reg != amc_pkg::H_IDLE) &&
                                         (state_reg != amc_pkg::H_WAIT);
          rdata_next[amc_pkg::LV_WAIT] = (state_reg == amc_pkg::H_WAIT);
        end
        amc_pkg::REG_MASK:  rdata_next = {13'h0000, mask_reg};
        amc_pkg::REG_LATCH: rdata_next = {4'h0, latch_reg};
        default: begin
          if (addr_i >= amc_pkg::REG_RES0 && addr_i < amc_pkg::REG_LATCH) begin
            rdata_next = {4'h0, res_reg[2'(addr_i - amc_pkg::REG_RES0)]};
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------

  // Control state; the reset wait starts at once.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= amc_pkg::H_WAIT;
      cnt_reg   <= '0;
      wake_reg  <= 1'b0;
      pd_reg    <= 1'b0;
      word_reg  <= 4'h0;
      sel_reg   <= 2'h0;
      idx_reg   <= 2'h0;
      latch_reg <= 12'h000;
      st_reg    <= '0;
      mask_reg  <= '0;
      irq_reg   <= 1'b0;
      rdata_reg <= 16'h0000;
      cs_n_reg  <= 1'b1;
      wr_n_reg  <= 1'b1;
      rd_n_reg  <= 1'b1;
      cv_n_reg  <= 1'b1;
      oe_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      wake_reg  <= wake_next;
      pd_reg    <= pd_next;
      word_reg  <= word_next;
      sel_reg   <= sel_next;
      idx_reg   <= idx_next;
      latch_reg <= latch_next;
      st_reg    <= st_next;
      mask_reg  <= mask_next;
      irq_reg   <= irq_next;
      rdata_reg <= rdata_next;
      cs_n_reg  <= cs_n_next;
      wr_n_reg  <= wr_n_next;
      rd_n_reg  <= rd_n_next;
      cv_n_reg  <= cv_n_next;
      oe_reg    <= oe_next;
    end
  end

  // Captured result words, one per read pulse.
  always_ff @(posedge clk_i) begin
    if (res_we) begin
      res_reg[idx_reg] <= link.data;
    end
  end

  // Pins and port outputs straight from registers.
  assign link.cs_n            = cs_n_reg;
  assign link.wr_n            = wr_n_reg;
  assign link.rd_n            = rd_n_reg;
  assign link.convert_start_n = cv_n_reg;
  assign link.addr_bits       = word_reg[1:0];
  assign link.host_dout       = {10'h000, word_reg[3:2]};
  assign link.host_oe         = oe_reg;
  assign rdata_o              = rdata_reg;
  assign irq_o                = irq_reg;
endmodule : amc_host

/* File: verification/amc_link_monitor.sv */
// Concurrent checks on the link between host and converter.
`timescale 1ns/10ps
module amc_link_monitor (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic cs_n,
  input  wire logic wr_n,
  input  wire logic rd_n,
  input  wire logic convert_start_n,
  input  wire logic done_n,
  input  wire logic host_oe,
  input  wire logic dev_oe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Four read strobes, one every five cycles.
  sequence four_reads;
    $fell(rd_n) ##5 $fell(rd_n) ##5 $fell(rd_n) ##5 $fell(rd_n);
  endsequence
  // Selected write with the host driving the pins.
  sequence wr_pulse;
    !cs_n && host_oe ##1 !wr_n ##1 wr_n && !cs_n;
  endsequence
  chk_reset_done: assert property (disable iff (1'b0) rst_i |=> done_n && !dev_oe)
    else $error("done or data drive wrong in reset");
  chk_done_reads: assert property ($fell(done_n) |-> ##[1:2] four_reads)
    else $error("done not followed by four reads");
  chk_read_release: assert property ($fell(rd_n) && !cs_n |=> done_n && dev_oe)
    else $error("read fall did not release done");
  chk_done_holds: assert property (!done_n && rd_n |=> !done_n)
    else $error("done dropped before a read");
  chk_word_write: assert property ($fell(wr_n) |-> wr_pulse)
    else $error("control word write malformed");
  chk_read_width: assert property ($fell(rd_n) |-> !cs_n ##1 !rd_n [*2] ##1 rd_n)
    else $error("read strobe malformed");
  chk_no_fight: assert property (!(dev_oe && host_oe))
    else $error("both ends drive the pins");
  chk_desel_quiet: assert property (cs_n [*2] |-> !dev_oe)
    else $error("device drives while deselected");
  chk_start_width: assert property ($fell(convert_start_n) |=> !convert_start_n ##1
                                    convert_start_n)
    else $error("convert start pulse malformed");
endmodule : amc_link_monitor

/* File: verification/testbench.sv */
// Self-checking bench joining the host and converter ends.
`timescale 1ns/10ps
module testbench;
  logic        clk_i, rst_i, wr_i, rd_i, pin, ext, irq_o, rdy, busy, pd;
  logic [3:0]  addr_i;
  logic [15:0] wdata_i, rdata_o, d;
  logic [47:0] sa, sb;
  logic [2:0]  mode;
  int          fails, n_tests, s, ph;
  amc_link_if lk ();
  amc_device #(.OSC_START_CYC(20)) u_amc_device (.clk_i, .rst_i, .link(lk.dev),
    .clk_pin_i(pin), .samp_a_i(sa), .samp_b_i(sb), .ready_o(rdy), .busy_o(busy),
    .powered_down_o(pd), .mode_o(mode));
  amc_host #(.WAKE_CYC(50)) u_amc_host (.clk_i, .rst_i, .link(lk.host), .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o);
  amc_link_monitor u_amc_link_monitor (.clk_i, .rst_i, .cs_n(lk.cs_n), .wr_n(lk.wr_n),
    .rd_n(lk.rd_n), .convert_start_n(lk.convert_start_n), .done_n(lk.done_n),
    .host_oe(lk.host_oe), .dev_oe(lk.dev_oe));
  // Compares a value seen against the one expected.
  task automatic chk(string n, logic [15:0] g, logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // Register write, then time for the link write to land.
  task automatic wr(logic [3:0] a, logic [15:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : wr
  // Register read; data stand in the cycle after the strobe.
  task automatic rd(logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  // Polls a status bit under a bounded count.
  task automatic poll(int b);
    rd(amc_pkg::REG_STAT);
    for (int i = 0; i < 3000 && d[b] !== 1'b1; i++) rd(amc_pkg::REG_STAT);
    chk("status", d & (16'h1 << b), 16'h1 << b);
  endtask : poll
  // Expected result: offset-binary sample with the sign bit inverted.
  function automatic logic [15:0] ex(logic [47:0] v, int c);
    return {4'h0, ~v[c*12+11], v[c*12+:11]};
  endfunction : ex
  // Programs mode m, converts, then checks busy, idle, irq and the readout.
  task automatic conv(int m);
    s = $urandom_range(m % 4, 0);
    wr(amc_pkg::REG_WORD, 16'(m));
    wr(amc_pkg::REG_SEL, 16'(s));
    wr(amc_pkg::REG_START, 16'h0001);
    chk("busy", {14'h0, busy, rdy}, 16'h0002);
    poll(amc_pkg::EV_DONE);
    chk("idle", {14'h0, busy, rdy}, 16'h0001);
    chk("mode", {13'h0, mode}, 16'(m));
    chk("irq", {15'h0, irq_o}, 16'h0001);
    for (int c = 0; c <= m % 4; c++) begin
      rd(amc_pkg::REG_RES0 + 4'(c));
      chk("result", d, ex(m > 3 ? sb : sa, c));
    end
    rd(amc_pkg::REG_LATCH);
    chk("latch", d, ex(m > 3 ? sb : sa, s));
    wr(amc_pkg::REG_STAT, 16'h0007);
    chk("irq", {15'h0, irq_o}, 16'h0000);
  endtask : conv
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  // Clock of 20 ns period.
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Clock pin: held high for the internal oscillator, or 40% duty over five cycles.
  always @(posedge clk_i) begin
    ph  <= (ph == 4) ? 0 : ph + 1;
    pin <= ext ? (ph < 2) : 1'b1;
  end
  // Watchdog that cuts a hang short.
  initial begin
    #1500000;
    fails++;
    conclude();
  end
  // Main sequence.
  initial begin
    {rst_i, wr_i, rd_i, ext} = 4'b1000;
    {addr_i, wdata_i, sa, sb, d} = '0;
    void'($urandom(32'ha829b613));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk("mode", {13'h0, mode}, 16'h0000);
    poll(amc_pkg::EV_READY);
    $display("reset test done");
    wr(amc_pkg::REG_MASK, 16'h0001);
    for (int m = 0; m < 8; m++) begin
      sa <= 48'({$urandom, $urandom});
      sb <= 48'({$urandom, $urandom});
      conv(m);
    end
    $display("mode test done");
    wr(amc_pkg::REG_WORD, 16'h0008);
    chk("pd", {15'h0, pd}, 16'h0001);
    wr(amc_pkg::REG_START, 16'h0001);
    rd(amc_pkg::REG_STAT);
    chk("refuse", d & 16'h0005, 16'h0004);
    wr(amc_pkg::REG_STAT, 16'h0007);
    wr(amc_pkg::REG_WORD, 16'h0006);
    chk("wake", {12'h0, pd, mode}, 16'h0006);
    poll(amc_pkg::EV_READY);
    rd(4'hf);
    chk("unmapped", d, 16'h0000);
    $display("power test done");
    // Second reset with the clock pin toggling selects the external clock.
    rst_i <= 1'b1;
    ext   <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk("mode", {13'h0, mode}, 16'h0000);
    poll(amc_pkg::EV_READY);
    wr(amc_pkg::REG_MASK, 16'h0001);
    conv(3);
    $display("external clock test done");
    conclude();
  end
endmodule : testbench
